// *** pkg/fbch_defines.vh ***
// Constants of the fieldbus command handshake block.
// Included by the design file; holds definitions only.
`ifndef FBCH_DEFINES_VH
`define FBCH_DEFINES_VH

// Error field codes
`define FBCH_ERR_NONE    8'h00
`define FBCH_ERR_TRIG    8'h01
`define FBCH_ERR_SWAP    8'h02
`define FBCH_ERR_OPERATE 8'h03

// Reset values
`define FBCH_RST_FRAME   8'h00
`define FBCH_RST_SLOT    8'h00
`define FBCH_RST_TAG     8'h00

// Settling time of a command before its result is applied:
// 40 ns at the 4 ns clock, in cycles
`define FBCH_EXEC_CYC    8'h0A

`endif

// *** src/fbch_handshake.v ***
// Fieldbus command handshake: the camera's side of the control/status image.
// Assumes control image bits arrive from logic on clk (fieldbus stack) and
// that the imaging core reports capture/job/operate outcomes as pulses on clk.
`timescale 1ns/100ps
`include "fbch_defines.vh"

module fbch_handshake (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Control image from the controller
    input  wire       triggerRequest,
    input  wire       program_swap_request,
    input  wire       enter_operate_request,
    input  wire       faultClear,
    input  wire [7:0] targetSlot,
    input  wire [7:0] requestTag,
    // Request channel: response of the command engine
    input  wire       responseDone,
    // Imaging core
    input  wire       coreBusy,
    input  wire       triggerFail,
    input  wire       slotValid,
    input  wire       operateFail,
    input  wire       jobExecuted,
    // Request channel to the command engine
    output reg        commandStart,
    // Capture start to the imaging core
    output reg        captureStart,
    // Status image to the controller
    output reg        ready,
    output reg        triggerAcknowledge,
    output reg        program_swap_acknowledge,
    output reg        enter_operate_acknowledge,
    output reg        operateMode,
    output reg  [7:0] errorCode,
    output reg  [7:0] frame_sequence_count,
    output reg  [7:0] activeSlot,
    output reg  [7:0] responseTag
);

    // One-hot command states
    localparam [3:0] ST_IDLE = 4'h1;
    localparam [3:0] ST_EXEC = 4'h2;
    localparam [3:0] ST_ACK  = 4'h4;
    localparam [3:0] ST_FAIL = 4'h8;

    // Command kinds
    localparam [1:0] CMD_TRIG = 2'h0;
    localparam [1:0] CMD_SWAP = 2'h1;
    localparam [1:0] CMD_OPER = 2'h2;

    localparam [7:0] EXEC_CYC = `FBCH_EXEC_CYC;

    // Command sequencer
    reg  [3:0] state_q;
    reg  [3:0] state_d;
    reg  [1:0] cmd_q;
    reg  [1:0] cmd_d;
    reg  [7:0] wait_q;
    reg  [7:0] wait_d;
    reg        execFail;
    // Request levels of the previous cycle
    reg        trigPrev_q;
    reg        swapPrev_q;
    reg        operPrev_q;
    // Job change failure, held until a good job change
    reg        swapFailed_q;
    // Generic request channel
    reg  [7:0] pendTag_q;
    reg        tagBusy_q;

    // Low-to-high step of a request level
    function rise;
        input now;
        input prev;
        begin
            rise = now & ~prev;
        end
    endfunction

    // Request still held for the command being acknowledged
    function held;
        input [1:0] cmd;
        input       t;
        input       s;
        input       o;
        begin
            held = (cmd == CMD_TRIG) ? t : (cmd == CMD_SWAP) ? s : o;
        end
    endfunction

    // Error code reported by a failed command
    function [7:0] failCode;
        input [1:0] cmd;
        begin
            if (cmd == CMD_TRIG) begin
                failCode = `FBCH_ERR_TRIG;
            end else if (cmd == CMD_SWAP) begin
                failCode = `FBCH_ERR_SWAP;
            end else begin
                failCode = `FBCH_ERR_OPERATE;
            end
        end
    endfunction

    wire trigRise = rise(triggerRequest, trigPrev_q);
    wire swapRise = rise(program_swap_request, swapPrev_q);
    wire operRise = rise(enter_operate_request, operPrev_q);
    wire reqHeld  = held(cmd_q, triggerRequest, program_swap_request,
                         enter_operate_request);
    // Last execution cycle: the outcome is applied here
    wire execLast = (state_q == ST_EXEC) & (wait_q <= 8'h01);
    wire trigLost = (cmd_q == CMD_TRIG) & execFail;
    wire ackRise  = execLast & ~trigLost;
    wire ackFall  = (state_q == ST_ACK) & ~reqHeld;

    // Outcome of the command under execution
    always @* begin
        execFail = 1'b0;
        if (cmd_q == CMD_TRIG) begin
            execFail = triggerFail | coreBusy;
        end else if (cmd_q == CMD_SWAP) begin
            execFail = ~slotValid;
        end else begin
            execFail = operateFail | operateMode;
        end
    end

    // Next state of the command sequencer
    always @* begin
        state_d = state_q;
        cmd_d   = cmd_q;
        wait_d  = wait_q;
        case (state_q)
            ST_IDLE: begin
                wait_d = EXEC_CYC;
                // One command at a time, trigger first
                if (trigRise) begin
                    cmd_d   = CMD_TRIG;
                    state_d = ST_EXEC;
                end else if (swapRise) begin
                    cmd_d   = CMD_SWAP;
                    state_d = ST_EXEC;
                end else if (operRise) begin
                    cmd_d   = CMD_OPER;
                    state_d = ST_EXEC;
                end
            end
            ST_EXEC: begin
                // Rises seen here are dropped, no ack and no error
                if (!execLast) begin
                    wait_d = wait_q - 8'h01;
                end else if (trigLost) begin
                    state_d = ST_FAIL;
                end else begin
                    state_d = ST_ACK;
                end
            end
            ST_ACK: begin
                // Ack falls once the controller drops its request
                if (!reqHeld) begin
                    state_d = ST_IDLE;
                end
            end
            ST_FAIL: begin
                if (!triggerRequest) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cmd_q   <= CMD_TRIG;
            wait_q  <= 8'h00;
        end else begin
            state_q <= state_d;
            cmd_q   <= cmd_d;
            wait_q  <= wait_d;
        end
    end

    // Request edge detection
    always @(posedge clk) begin
        if (sys_rst) begin
            trigPrev_q <= 1'b0;
            swapPrev_q <= 1'b0;
            operPrev_q <= 1'b0;
        end else begin
            trigPrev_q <= triggerRequest;
            swapPrev_q <= program_swap_request;
            operPrev_q <= enter_operate_request;
        end
    end

    // Ready: idle, core free, no failed job change, no clear pending
    always @(posedge clk) begin
        if (sys_rst) begin
            ready <= 1'b0;
        end else begin
            ready <= (state_q == ST_IDLE) & ~coreBusy & ~swapFailed_q
                     & ~faultClear;
        end
    end

    // Acknowledge bits and capture launch
    always @(posedge clk) begin
        if (sys_rst) begin
            triggerAcknowledge        <= 1'b0;
            program_swap_acknowledge  <= 1'b0;
            enter_operate_acknowledge <= 1'b0;
            captureStart              <= 1'b0;
        end else begin
            captureStart <= ackRise & (cmd_q == CMD_TRIG);
            if (ackFall) begin
                triggerAcknowledge        <= 1'b0;
                program_swap_acknowledge  <= 1'b0;
                enter_operate_acknowledge <= 1'b0;
            end else if (ackRise) begin
                triggerAcknowledge        <= (cmd_q == CMD_TRIG);
                program_swap_acknowledge  <= (cmd_q == CMD_SWAP);
                enter_operate_acknowledge <= (cmd_q == CMD_OPER);
            end
        end
    end

    // Error field: a new error wins over a clear in the same cycle
    always @(posedge clk) begin
        if (sys_rst) begin
            errorCode <= `FBCH_ERR_NONE;
        end else if (execLast & execFail) begin
            errorCode <= failCode(cmd_q);
        end else if (faultClear) begin
            errorCode <= `FBCH_ERR_NONE;
        end
    end

    // Run mode, entered by a good switch to run and then kept
    always @(posedge clk) begin
        if (sys_rst) begin
            operateMode <= 1'b0;
        end else if (execLast & (cmd_q == CMD_OPER) & ~execFail) begin
            operateMode <= 1'b1;
        end
    end

    // Program slot echo and sticky job change failure
    always @(posedge clk) begin
        if (sys_rst) begin
            activeSlot   <= `FBCH_RST_SLOT;
            swapFailed_q <= 1'b0;
        end else if (execLast & (cmd_q == CMD_SWAP)) begin
            if (execFail) begin
                swapFailed_q <= 1'b1;
            end else begin
                activeSlot   <= targetSlot;
                swapFailed_q <= 1'b0;
            end
        end
    end

    // Frame counter, wraps after 255
    always @(posedge clk) begin
        if (sys_rst) begin
            frame_sequence_count <= `FBCH_RST_FRAME;
        end else if (jobExecuted) begin
            frame_sequence_count <= frame_sequence_count + 8'h01;
        end
    end

    // Generic request channel: tag change starts a command, tag echoed later
    always @(posedge clk) begin
        if (sys_rst) begin
            pendTag_q    <= `FBCH_RST_TAG;
            tagBusy_q    <= 1'b0;
            commandStart <= 1'b0;
            responseTag  <= `FBCH_RST_TAG;
        end else begin
            commandStart <= 1'b0;
            if (!tagBusy_q && requestTag != responseTag) begin
                pendTag_q    <= requestTag;
                tagBusy_q    <= 1'b1;
                commandStart <= 1'b1;
            end else if (tagBusy_q && responseDone) begin
                responseTag <= pendTag_q;
                tagBusy_q   <= 1'b0;
            end
        end
    end

endmodule

// *** verification/fbch_props.sv ***
// Concurrent checks on the status image and the capture/command start outputs of the handshake block.
// Assumes it is bound to fbch_handshake, port names matching.
`timescale 1ns/100ps
module fbch_props (
    // Clock, reset, control image, command engine response and job pulse
    input wire       clk, sys_rst, triggerRequest, faultClear,
    input wire       responseDone, jobExecuted,
    input wire [7:0] requestTag,
    // Status image, capture start and command start
    input wire       ready, triggerAcknowledge, operateMode,
    input wire       program_swap_acknowledge, enter_operate_acknowledge,
    input wire [7:0] errorCode, frame_sequence_count, responseTag,
    input wire       captureStart, commandStart
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence trigAnswer;
        ##[9:13] (triggerAcknowledge || errorCode == 8'h01);
    endsequence
    trig_answer_a: assert property (
        $rose(triggerRequest) && ready && !faultClear |-> trigAnswer)
        else $error("Trigger not answered");
    trig_fail_a: assert property (
        $changed(errorCode) && errorCode == 8'h01 |-> !triggerAcknowledge)
        else $error("Ack on failed trigger");
    swap_fail_a: assert property (
        $changed(errorCode) && errorCode == 8'h02
        |-> program_swap_acknowledge && !ready) else $error("Swap failure");
    run_fail_a: assert property (
        $changed(errorCode) && errorCode == 8'h03
        |-> enter_operate_acknowledge && !operateMode) else $error("Run fail");
    run_ok_a: assert property (
        $fell(enter_operate_acknowledge) && !faultClear |-> operateMode)
        else $error("Run mode not entered");
    err_clear_a: assert property (
        faultClear |=> errorCode == 8'h00) else $error("Error not cleared");
    frame_count_a: assert property (
        1'b1 |=> frame_sequence_count == $past(frame_sequence_count)
        + {7'h00, $past(jobExecuted)}) else $error("Frame count wrong");
    tag_mirror_a: assert property (
        $changed(responseTag) |-> responseTag == requestTag
        && $past(responseDone)) else $error("Tag mirror wrong");
    capture_launch_a: assert property (
        $rose(triggerAcknowledge) |-> captureStart)
        else $error("Capture not launched with trigger ack");
    command_start_a: assert property (
        commandStart |-> requestTag != responseTag)
        else $error("Command started without new tag");
endmodule
bind fbch_handshake fbch_props u_props (.*);

// *** verification/fbch_plc.sv ***
// Controller model: raises requests and holds them until answered.
// Assumes the status image comes from the handshake block on clk.
`timescale 1ns/100ps
module fbch_plc (
    // Clock and command from the bench
    input wire       clk,
    input wire       go,
    input wire [1:0] kind,
    // Status image
    input wire [2:0] acks,
    input wire [7:0] errorCode,
    // Control image
    output reg [2:0] req = 3'h0,
    output reg       faultClear = 1'b0
);
    always @(posedge clk) begin
        if (go)
            req <= req | (3'h1 << kind);
        else if (req != 3'h0 && (|(acks & req) || errorCode != 8'h00)) begin
            req <= 3'h0;
            faultClear <= errorCode != 8'h00;
        end else if (faultClear && errorCode == 8'h00)
            faultClear <= 1'b0;
    end
endmodule

// *** verification/testbench.sv ***
// Self-checking bench for the command handshake block.
// Assumes the controller model drives the control image.
`timescale 1ns/100ps
`define CHK(a, b) begin totalChecks++; if ((a) !== (b)) begin numErrors++; \
    $display("CHECK FAILED t=%0t %h %h", $time, a, b); end end
module testbench;
    reg        clk = 1'b0, sys_rst = 1'b1, go = 1'b0, coreBusy = 1'b0;
    reg        triggerFail = 1'b0, slotValid = 1'b0, operateFail = 1'b0;
    reg        jobExecuted = 1'b0, responseDone = 1'b0, sawAck = 1'b0;
    reg  [1:0] kind = 2'h0;
    reg  [7:0] targetSlot = 8'h00, requestTag = 8'h00, lastErr = 8'h00;
    wire [2:0] req, acks;
    wire       faultClear, commandStart, captureStart, ready, operateMode;
    wire       triggerAcknowledge, program_swap_acknowledge;
    wire       enter_operate_acknowledge;
    wire [7:0] errorCode, frame_sequence_count, activeSlot, responseTag;
    wire       triggerRequest = req[0];
    wire       program_swap_request = req[1];
    wire       enter_operate_request = req[2];
    integer    numErrors = 0, totalChecks = 0;
    assign acks = {enter_operate_acknowledge, program_swap_acknowledge,
                   triggerAcknowledge};
    fbch_handshake dut (.*);
    fbch_plc plc (.clk(clk), .go(go), .kind(kind), .acks(acks),
        .errorCode(errorCode), .req(req), .faultClear(faultClear));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        if (acks != 3'h0) sawAck <= 1'b1;
        if (errorCode != 8'h00) lastErr <= errorCode;
    end
    task completeRun;
        begin
            if (numErrors == 0 && totalChecks > 0) $display("NO MISMATCHES");
            else $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    // One command, waited to completion
    task issue(input [1:0] k);
        integer n;
        begin
            sawAck = 1'b0;
            lastErr = 8'h00;
            kind = k;
            go = 1'b1;
            @(negedge clk) go = 1'b0;
            for (n = 0; n < 99 && (req || faultClear || acks); n++)
                @(negedge clk);
            if (n == 99) begin
                numErrors++;
                completeRun;
            end
            // Ready is rebuilt one edge after the ack falls
            @(negedge clk);
        end
    endtask
    task trigCase;
        begin
            `CHK(ready, 1'b1)
            issue(2'h0);
            `CHK({sawAck, lastErr}, 9'h100)
            jobExecuted = 1'b1;
            @(negedge clk) jobExecuted = 1'b0;
            `CHK(frame_sequence_count, 8'h01)
            triggerFail = 1'b1;
            issue(2'h0);
            triggerFail = 1'b0;
            `CHK({sawAck, lastErr, errorCode}, 17'h00100)
        end
    endtask
    task swapCase;
        begin
            targetSlot = 8'h05;
            issue(2'h1);
            `CHK({lastErr, errorCode, ready}, 17'h00400)
            targetSlot = 8'h09;
            slotValid = 1'b1;
            issue(2'h1);
            `CHK({sawAck, lastErr, activeSlot, ready}, 18'h20013)
        end
    endtask
    task dropCase;
        begin
            kind = 2'h0;
            go = 1'b1;
            @(negedge clk) go = 1'b0;
            repeat (3) @(negedge clk);
            targetSlot = 8'h0C;
            issue(2'h1);
            `CHK({sawAck, activeSlot, lastErr}, 17'h10900)
        end
    endtask
    task runCase;
        begin
            `CHK({ready, operateMode}, 2'h2)
            operateFail = 1'b1;
            issue(2'h2);
            operateFail = 1'b0;
            `CHK({lastErr, operateMode}, 9'h006)
            issue(2'h2);
            `CHK({sawAck, operateMode, errorCode}, 10'h300)
        end
    endtask
    task tagCase;
        begin
            requestTag = 8'h01;
            @(negedge clk) `CHK(commandStart, 1'b1)
            repeat (3) @(negedge clk);
            `CHK(responseTag, 8'h00)
            responseDone = 1'b1;
            @(negedge clk) responseDone = 1'b0;
            @(negedge clk) `CHK(responseTag, 8'h01)
        end
    endtask
    initial begin
        repeat (2) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        trigCase;
        swapCase;
        dropCase;
        runCase;
        tagCase;
        completeRun;
    end
endmodule
